// File: dv/host_uart.sv
// serial host model: frames bytes to the device and collects its replies
`timescale 1ns/10ps
module host_uart (
    input wire logic clk_sys,
    output logic line_out,
    input wire logic line_in
);
    // line idles high between frames, as a pulled-up serial wire does
    initial line_out = 1'h1;
    task automatic send(input logic [7:0] b, input int bc);
        logic [9:0] frame;
        frame = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            line_out <= frame[i];
            repeat (bc) @(posedge clk_sys);
        end
    endtask
    task automatic recv(output logic [7:0] b, input int bc);
        int n;
        n = 0;
        while (line_in !== 1'h0 && n < 40000) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (bc / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (bc) @(posedge clk_sys);
            b[i] = line_in;
        end
        repeat (bc) @(posedge clk_sys);
        if (line_in !== 1'h1) b = 8'hxx;
    endtask
endmodule

// File: dv/motor_uart_chk.sv
// assertion checker for the motor serial command interpreter
`timescale 1ns/10ps
module motor_uart_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic simple_mode,
    input wire logic rx,
    input wire logic tx,
    input wire motor_uart_pkg::control_s ctrl,
    input wire logic slave_active,
    input wire logic autostop_tripped,
    input wire logic check_error
);
    import motor_uart_pkg::*;
    // cycles since rx was last low; no decoded change may appear far from line traffic
    logic [14:0] quiet;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            quiet <= 15'h7fff;
        end else if (!rx) begin
            quiet <= 15'h0000;
        end else if (quiet != 15'h7fff) begin
            quiet <= quiet + 15'h0001;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_trip;
        $rose(autostop_tripped);
    endsequence
    AST_TX_IDLE: assert property ($fell(rst) |-> tx) else $error("tx not idle after reset");
    AST_CHK_PULSE: assert property (check_error |=> !check_error) else $error("check error too long");
    AST_CHK_ADV: assert property (check_error |-> !simple_mode && quiet < 15'h55f0)
        else $error("check error without advanced traffic");
    AST_SIMPLE_IDLE: assert property (simple_mode [*3] |-> !slave_active) else $error("slave active in simple");
    AST_DIR_CODE: assert property (ctrl.dir != 2'h2) else $error("illegal direction code");
    AST_TRIP_STOPS: assert property (s_trip |-> ##[0:1] ctrl.dir == DIR_STOP) else $error("trip kept motor on");
    AST_TRIP_CAUSE: assert property (s_trip |-> $past(ctrl.autostop_on)) else $error("trip without autostop");
    AST_AUTO_SERIAL: assert property (ctrl.autostop_on |-> ctrl.serial_ctrl) else $error("autostop off serial");
    AST_SET_RX: assert property ($changed(ctrl.setting) |-> quiet < 15'h55f0) else $error("setting moved alone");
    AST_WAKE_RX: assert property ($rose(slave_active) |-> quiet < 15'h55f0 && !simple_mode)
        else $error("wake without address");
endmodule
bind motor_uart_command_interpreter motor_uart_chk i_chk (.clk_sys(clk_sys), .rst(rst), .simple_mode(simple_mode),
    .rx(rx), .tx(tx), .ctrl(ctrl), .slave_active(slave_active), .autostop_tripped(autostop_tripped),
    .check_error(check_error));

// File: dv/testbench.sv
// self-checking bench: simple autostop control and addressed writes with check byte
`timescale 1ns/10ps
module testbench;
    import motor_uart_pkg::*;
    localparam int AUTO = 2000;
    // bit periods cut tenfold so the run stays short; ratio kept
    localparam int BS = 208;
    localparam int BA = 104;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic simple_mode = 1'h1;
    logic rx;
    logic tx;
    measurements_s meas = '0;
    control_s ctrl;
    logic slave_active;
    logic autostop_tripped;
    logic check_error;
    logic err_seen = 1'h0;
    logic [7:0] reply;
    int num_errors = 0;
    int total_checks = 0;
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (check_error === 1'h1) err_seen <= 1'h1;
    host_uart i_host (.clk_sys(clk_sys), .line_out(rx), .line_in(tx));
    motor_uart_command_interpreter #(.AUTOSTOP_CYCLES(AUTO), .BIT_CYCLES_SIMPLE(12'(BS)),
        .BIT_CYCLES_ADV(12'(BA))) i_dut (.clk_sys(clk_sys), .rst(rst),
        .simple_mode(simple_mode), .rx(rx), .meas(meas), .tx(tx), .ctrl(ctrl), .slave_active(slave_active),
        .autostop_tripped(autostop_tripped), .check_error(check_error));
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // five-byte addressed write; a flipped check bit models a corrupted frame
    task automatic adv_write(input logic [6:0] addr, input logic [5:0] code, input logic [13:0] val, input logic bad);
        logic [7:0] cmd;
        logic [6:0] sum;
        cmd = {2'h1, code};
        sum = 7'(cmd + {1'h0, val[13:7]} + {1'h0, val[6:0]}) ^ {6'h00, bad};
        i_host.send({1'h1, addr}, BA);
        i_host.send(cmd, BA);
        i_host.send({1'h0, val[13:7]}, BA);
        i_host.send({1'h0, val[6:0]}, BA);
        fork
            i_host.send({1'h0, sum}, BA);
            i_host.recv(reply, BA);
        join
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        i_host.send(S_WR_DIR, BS);
        i_host.send(8'h01, BS);
        i_host.send(8'h84, BS);
        i_host.send(8'h0f, BS);
        fork
            i_host.send(8'hc4, BS);
            i_host.recv(reply, BS);
        join
        check(14'(reply), 14'h000f);
        check(ctrl.setting[4], 14'h000f);
        i_host.send(S_SERIAL_AUTO, BS);
        repeat (4) @(posedge clk_sys);
        check(14'(ctrl.dir), 14'(DIR_FWD));
        check(14'(ctrl.serial_ctrl & ctrl.autostop_on), 14'h0001);
        check(14'(autostop_tripped), 14'h0000);
        repeat (AUTO) @(posedge clk_sys);
        check(14'(ctrl.dir), 14'(DIR_STOP));
        check(14'(autostop_tripped), 14'h0001);
        i_host.send(S_SERIAL_CANCEL, BS);
        check(14'(ctrl.serial_ctrl), 14'h0000);
        check(14'(autostop_tripped), 14'h0000);
        simple_mode <= 1'h0;
        repeat (4) @(posedge clk_sys);
        adv_write(7'h00, A_SPEED, 14'h0123, 1'h0);
        check(14'(reply), 14'h0000);
        check(ctrl.setting[0], 14'h0123);
        check(14'(slave_active), 14'h0001);
        check(14'(err_seen), 14'h0000);
        adv_write(7'h00, A_SPEED, 14'h0456, 1'h1);
        check(14'(reply), 14'h0080);
        check(ctrl.setting[0], 14'h0123);
        check(14'(err_seen), 14'h0001);
        i_host.send(8'h80, BA);
        fork
            i_host.send({2'h0, A_SPEED}, BA);
            begin
                i_host.recv(reply, BA);
                check(14'(reply), 14'h0002);
                i_host.recv(reply, BA);
                check(14'(reply), 14'h0023);
                i_host.recv(reply, BA);
                check(14'(reply), 14'h0025);
            end
        join
        i_host.send(8'h85, BA);
        repeat (4) @(posedge clk_sys);
        check(14'(slave_active), 14'h0000);
        summarize();
    end
endmodule

// File: hdl/motor_uart_command_interpreter.sv
// serial command interpreter for the brushed motor controller, simple and addressed protocols
`timescale 1ns/10ps
// Notes on behaviour
// - switch 4 on selects simple protocol
// - simple protocol runs at 9600 baud
// - advanced protocol runs at 19200 baud
// - frames: start, eight data, stop, no parity
// - one read command, device answers one byte
// - 0x80, 0x82-0x89 load seven-bit settings
// - 0xC0, 0xC2-0xC9 read those settings back
// - 0x8A sets stop, forward or regen
// - 0xE0 serial control, stop after 3 s
// - 0xE1 serial control, speed holds forever
// - 0xE2 returns control to potentiometers
// - 0xCA-0xD5 return measurements and bit words; 0xCB is not decoded here and gets no answer
// - advanced: accept only own address, else standby
// - stay active until foreign address arrives
// - address bytes top bit one, others zero
// - write check is seven-bit sum, verified
// - reply address, or address with 0x80 on error
// - two-byte read, three-byte answer
// - answer check is seven-bit sum
// - 0xA0/0xA1 write saving bit halves
// - fourteen-bit values split seven high, seven low
// - address set by 0x7C, resets to zero
module motor_uart_command_interpreter #(
    parameter int AUTOSTOP_CYCLES = motor_uart_pkg::AUTOSTOP_CYC,
    parameter logic [11:0] BIT_CYCLES_SIMPLE = motor_uart_pkg::BIT_CYC_SIMPLE, // clocks per bit, may be scaled
    parameter logic [11:0] BIT_CYCLES_ADV = motor_uart_pkg::BIT_CYC_ADV,
    parameter logic [13:0] SW_VERSION = 14'h0011, // arbitrary value
    parameter logic [13:0] HW_VERSION = 14'h0022 // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic simple_mode,
    input wire logic rx,
    input wire motor_uart_pkg::measurements_s meas,
    output logic tx,
    output motor_uart_pkg::control_s ctrl,
    output logic slave_active,
    output logic autostop_tripped,
    output logic check_error
);
    import motor_uart_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SDATA,
        ST_ACMD,
        ST_AD1,
        ST_AD2,
        ST_ACHK
    } proto_state_e;

    proto_state_e state;
    proto_state_e next_state;
    logic mode_q;
    logic [7:0] cmd;
    logic [6:0] d1;
    logic [6:0] d2;
    logic [6:0] own_addr;
    logic [11:0] bit_cycles;
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_start;
    logic [7:0] tx_data;
    logic tx_ready;
    logic [13:0] setting [NUM_SETTINGS];
    logic [1:0] dir;
    logic [13:0] lock;
    logic [13:0] save1;
    logic [13:0] save2;
    logic [13:0] cfg1;
    logic [13:0] cfg2;
    logic [13:0] cal;
    logic serial_ctrl;
    logic autostop_on;
    logic [31:0] stop_cnt;
    logic wr_en;
    logic [5:0] wr_code;
    logic [13:0] wr_data;
    logic [13:0] wr_mask;
    logic dir_we;
    logic sc_auto;
    logic sc_hold;
    logic sc_cancel;
    logic addr_seen;
    logic addr_match;
    logic chk_bad;
    logic [1:0] load_n;
    logic [7:0] load_b0;
    logic [7:0] load_b1;
    logic [7:0] load_b2;
    logic [7:0] tx_q [3];
    logic [1:0] tx_cnt;
    logic [5:0] rd_code;
    logic rd_high;
    logic [13:0] rd_word;
    logic [7:0] srd;

    // seven-bit additive check shared by write verification and read answers
    function automatic logic [6:0] chk7(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        logic [7:0] sum;
        sum = 8'(a + b + c);
        return sum[6:0] & CHK_MASK;
    endfunction

    function automatic logic is_simple_write(input logic [7:0] b);
        return (b >= S_WR_SPEED && b <= S_WR_DIR && b != S_WR_UNUSED) || b == S_SAVE_LO || b == S_SAVE_HI;
    endfunction

    // maps a simple read command to {valid, high half, register code}
    function automatic logic [7:0] simple_read_map(input logic [7:0] b);
        logic [7:0] m;
        m = 8'h00;
        if (b >= S_RD_FIRST && b <= S_RD_LAST_SET && b != (S_RD_FIRST + 8'h01)) begin
            m = {2'b10, 2'b00, b[3:0]};
        end else begin
            unique case (b)
                S_RD_CURRENT: m = {2'b11, A_CURRENT};
                S_RD_SUPPLY: m = {2'b11, A_SUPPLY};
                S_RD_SPEED_IN: m = {2'b11, A_SPEED_IN};
                S_RD_HEATSINK: m = {2'b10, A_HEATSINK};
                S_RD_BOARD: m = {2'b10, A_BOARD};
                S_RD_STAT_LO: m = {2'b10, A_STATUS};
                S_RD_STAT_HI: m = {2'b11, A_STATUS};
                S_RD_CFG1_LO: m = {2'b10, A_CFG1};
                S_RD_CFG1_HI: m = {2'b11, A_CFG1};
                S_RD_CFG2_LO: m = {2'b10, A_CFG2};
                S_RD_CFG2_HI: m = {2'b11, A_CFG2};
                S_RD_SW_VER: m = {2'b10, A_SW_VER};
                S_RD_HW_VER: m = {2'b10, A_HW_VER};
                default: m = 8'h00;
            endcase
        end
        return m;
    endfunction

    assign bit_cycles = simple_mode ? BIT_CYCLES_SIMPLE : BIT_CYCLES_ADV;

    serial_port u_port (
        .clk_sys(clk_sys),
        .rst(rst),
        .bit_cycles(bit_cycles),
        .rx(rx),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .tx_start(tx_start),
        .tx_data(tx_data),
        .tx_ready(tx_ready),
        .tx(tx)
    );

    assign srd = simple_read_map(rx_data);
    assign rd_code = simple_mode ? srd[5:0] : rx_data[5:0];
    assign rd_high = simple_mode && srd[6];

    always_comb begin
        unique case (rd_code)
            A_HEATSINK: rd_word = meas.heatsink_temp;
            A_BOARD: rd_word = meas.board_temp;
            A_SUPPLY: rd_word = meas.supply;
            A_SPEED_IN: rd_word = meas.speed_in;
            A_CURRENT: rd_word = meas.current;
            A_STATUS: rd_word = meas.status;
            A_LOCK: rd_word = lock;
            A_SAVE1: rd_word = save1;
            A_SAVE2: rd_word = save2;
            A_CFG1: rd_word = cfg1;
            A_CFG2: rd_word = cfg2;
            A_SW_VER: rd_word = SW_VERSION;
            A_HW_VER: rd_word = HW_VERSION;
            default: rd_word = (rd_code < 6'(NUM_SETTINGS)) ? setting[rd_code[3:0]] : 14'h0000;
        endcase
    end

    assign addr_seen = rx_valid && rx_data[ADDR_FLAG_BIT];
    assign addr_match = rx_data[6:0] == own_addr;
    assign chk_bad = chk7(cmd, {1'b0, d1}, {1'b0, d2}) != rx_data[6:0];

    // decodes each received byte against the protocol position
    always_comb begin
        next_state = state;
        wr_en = 1'b0;
        wr_code = 6'h00;
        wr_data = 14'h0000;
        wr_mask = FULL_MASK;
        dir_we = 1'b0;
        sc_auto = 1'b0;
        sc_hold = 1'b0;
        sc_cancel = 1'b0;
        load_n = 2'd0;
        load_b0 = 8'h00;
        load_b1 = 8'h00;
        load_b2 = 8'h00;
        if (!rx_valid) begin
            next_state = state;
        end else if (simple_mode) begin
            if (state == ST_SDATA && !rx_data[7]) begin
                next_state = ST_IDLE;
                wr_en = cmd != S_WR_DIR;
                wr_code = {2'b00, cmd[3:0]};
                wr_data = {7'h00, rx_data[6:0]};
                dir_we = cmd == S_WR_DIR;
                if (cmd == S_SAVE_LO) begin
                    wr_code = A_SAVE1;
                    wr_mask = LOW_MASK;
                end else if (cmd == S_SAVE_HI) begin
                    wr_code = A_SAVE1;
                    wr_data = {rx_data[6:0], 7'h00};
                    wr_mask = HIGH_MASK;
                end
            end else if (rx_data[7]) begin
                // a command byte always restarts, so a lost data byte cannot shift later pairs
                next_state = is_simple_write(rx_data) ? ST_SDATA : ST_IDLE;
                sc_auto = rx_data == S_SERIAL_AUTO;
                sc_hold = rx_data == S_SERIAL_HOLD;
                sc_cancel = rx_data == S_SERIAL_CANCEL;
                if (srd[7]) begin
                    load_n = 2'd1;
                    load_b0 = {1'b0, rd_high ? rd_word[13:7] : rd_word[6:0]};
                end
            end
        end else if (addr_seen) begin
            next_state = addr_match ? ST_ACMD : ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: next_state = ST_IDLE;
                ST_SDATA: next_state = ST_IDLE;
                ST_ACMD: begin
                    if (rx_data[WRITE_FLAG_BIT]) begin
                        next_state = ST_AD1;
                    end else begin
                        next_state = ST_IDLE;
                        load_n = 2'd3;
                        load_b0 = {1'b0, rd_word[13:7]};
                        load_b1 = {1'b0, rd_word[6:0]};
                        load_b2 = {1'b0, chk7(rx_data, {1'b0, rd_word[13:7]}, {1'b0, rd_word[6:0]})};
                    end
                end
                ST_AD1: next_state = ST_AD2;
                ST_AD2: next_state = ST_ACHK;
                ST_ACHK: begin
                    next_state = ST_IDLE;
                    wr_en = !chk_bad;
                    wr_code = cmd[5:0];
                    wr_data = {d1, d2};
                    load_n = 2'd1;
                    load_b0 = {chk_bad, own_addr};
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            mode_q <= 1'b0;
            cmd <= 8'h00;
            d1 <= 7'h00;
            d2 <= 7'h00;
        end else begin
            mode_q <= simple_mode;
            // a mode switch drops any half-received transaction
            state <= (mode_q != simple_mode) ? ST_IDLE : next_state;
            if (rx_valid && (state == ST_IDLE || state == ST_ACMD || rx_data[7])) begin
                cmd <= rx_data;
            end
            if (rx_valid && state == ST_AD1) begin
                d1 <= rx_data[6:0];
            end
            if (rx_valid && state == ST_AD2) begin
                d2 <= rx_data[6:0];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slave_active <= 1'b0;
            check_error <= 1'b0;
        end else begin
            check_error <= rx_valid && !simple_mode && !addr_seen && state == ST_ACHK && chk_bad;
            if (simple_mode) begin
                slave_active <= 1'b0;
            end else if (addr_seen) begin
                slave_active <= addr_match;
            end
        end
    end

    for (genvar i = 0; i < NUM_SETTINGS; i++) begin : g_set
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                setting[i] <= SETTING_RESET;
            end else if (wr_en && wr_code == 6'(i)) begin
                setting[i] <= (setting[i] & ~wr_mask) | (wr_data & wr_mask);
            end
        end
        assign ctrl.setting[i] = setting[i];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock <= 14'h0000;
            save1 <= 14'h0000;
            save2 <= 14'h0000;
            cfg1 <= 14'h0000;
            cfg2 <= 14'h0000;
            cal <= 14'h0000;
            own_addr <= ADDR_RESET;
        end else if (wr_en) begin
            unique case (wr_code)
                A_LOCK: lock <= wr_data;
                A_SAVE1: save1 <= (save1 & ~wr_mask) | (wr_data & wr_mask);
                A_SAVE2: save2 <= wr_data;
                A_CFG1: cfg1 <= wr_data;
                A_CFG2: cfg2 <= wr_data;
                A_CAL: cal <= wr_data;
                A_ADDR: own_addr <= wr_data[6:0];
                default: lock <= lock;
            endcase
        end
    end

    // serial control and autostop; a speed write restarts the window
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            serial_ctrl <= 1'b0;
            autostop_on <= 1'b0;
            stop_cnt <= 32'h0000_0000;
            autostop_tripped <= 1'b0;
            dir <= DIR_STOP;
        end else begin
            if (sc_auto || sc_hold) begin
                serial_ctrl <= 1'b1;
                autostop_on <= sc_auto;
            end else if (sc_cancel) begin
                serial_ctrl <= 1'b0;
                autostop_on <= 1'b0;
            end
            if (sc_auto || sc_hold || sc_cancel || (wr_en && wr_code == A_SPEED)) begin
                stop_cnt <= 32'h0000_0000;
                autostop_tripped <= 1'b0;
            end else if (serial_ctrl && autostop_on && !autostop_tripped) begin
                if (stop_cnt == 32'(AUTOSTOP_CYCLES - 1)) begin
                    autostop_tripped <= 1'b1;
                end else begin
                    stop_cnt <= stop_cnt + 32'h0000_0001;
                end
            end
            // a restart in the expiry cycle wins, matching the trip flag
            if (serial_ctrl && autostop_on && !autostop_tripped && stop_cnt == 32'(AUTOSTOP_CYCLES - 1)
                && !sc_auto && !sc_hold && !sc_cancel && !(wr_en && wr_code == A_SPEED)) begin
                dir <= DIR_STOP;
            end else if (dir_we && (rx_data[6:0] == 7'(DIR_STOP) || rx_data[6:0] == 7'(DIR_FWD)
                         || rx_data[6:0] == 7'(DIR_REGEN))) begin
                dir <= rx_data[1:0];
            end
        end
    end

    assign ctrl.dir = dir;
    assign ctrl.lock = lock;
    assign ctrl.save1 = save1;
    assign ctrl.save2 = save2;
    assign ctrl.cfg1 = cfg1;
    assign ctrl.cfg2 = cfg2;
    assign ctrl.cal = cal;
    assign ctrl.serial_ctrl = serial_ctrl;
    assign ctrl.autostop_on = autostop_on;

    // reply queue; a new reply replaces one still pending, the host paces itself on replies
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_q[0] <= 8'h00;
            tx_q[1] <= 8'h00;
            tx_q[2] <= 8'h00;
            tx_cnt <= 2'd0;
            tx_start <= 1'b0;
            tx_data <= 8'h00;
        end else if (load_n != 2'd0) begin
            tx_q[0] <= load_b0;
            tx_q[1] <= load_b1;
            tx_q[2] <= load_b2;
            tx_cnt <= load_n;
            tx_start <= 1'b0;
        end else if (tx_ready && !tx_start && tx_cnt != 2'd0) begin
            tx_start <= 1'b1;
            tx_data <= tx_q[0];
            tx_q[0] <= tx_q[1];
            tx_q[1] <= tx_q[2];
            tx_cnt <= tx_cnt - 2'd1;
        end else begin
            tx_start <= 1'b0;
        end
    end
endmodule

// File: hdl/serial_port.sv
// one-start, eight-data, one-stop serial receiver and transmitter
`timescale 1ns/10ps
module serial_port (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [11:0] bit_cycles,
    input wire logic rx,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic tx_start,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic tx
);
    import motor_uart_pkg::*;

    logic rx_busy;
    logic [11:0] rx_cnt;
    logic [3:0] rx_bit;
    logic tx_busy;
    logic [11:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [8:0] tx_frame;

    // receiver samples mid-bit; a start bit that is high again at mid-bit is a glitch
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_busy <= 1'b0;
            rx_cnt <= 12'h000;
            rx_bit <= 4'h0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (!rx_busy) begin
                if (!rx) begin
                    rx_busy <= 1'b1;
                    rx_cnt <= bit_cycles >> 1;
                    rx_bit <= 4'h0;
                end
            end else if (rx_cnt != 12'h000) begin
                rx_cnt <= rx_cnt - 12'h001;
            end else begin
                rx_cnt <= bit_cycles - 12'h001;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0) begin
                    rx_busy <= !rx;
                end else if (rx_bit == FRAME_LAST_BIT) begin
                    rx_busy <= 1'b0;
                    rx_valid <= rx;
                end else begin
                    rx_data <= {rx, rx_data[7:1]};
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_busy <= 1'b0;
            tx_cnt <= 12'h000;
            tx_bit <= 4'h0;
            tx_frame <= 9'h1ff;
            tx <= 1'b1;
        end else if (!tx_busy) begin
            if (tx_start) begin
                tx_busy <= 1'b1;
                tx_frame <= {1'b1, tx_data};
                tx <= 1'b0;
                tx_cnt <= bit_cycles - 12'h001;
                tx_bit <= 4'h0;
            end
        end else if (tx_cnt != 12'h000) begin
            tx_cnt <= tx_cnt - 12'h001;
        end else if (tx_bit == FRAME_LAST_BIT) begin
            tx_busy <= 1'b0;
        end else begin
            tx <= tx_frame[0];
            tx_frame <= {1'b1, tx_frame[8:1]};
            tx_bit <= tx_bit + 4'h1;
            tx_cnt <= bit_cycles - 12'h001;
        end
    end

    assign tx_ready = !tx_busy;
endmodule

// File: include/motor_uart_pkg.sv
// constants, codes and carrier types for the motor serial command interpreter
package motor_uart_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_SIMPLE = 9600;
    localparam int BAUD_ADV = 19200;
    localparam logic [11:0] BIT_CYC_SIMPLE = 12'(CLK_HZ / BAUD_SIMPLE);
    localparam logic [11:0] BIT_CYC_ADV = 12'(CLK_HZ / BAUD_ADV);
    localparam int AUTOSTOP_SEC = 3;
    localparam int AUTOSTOP_CYC = CLK_HZ * AUTOSTOP_SEC;
    localparam logic [3:0] FRAME_LAST_BIT = 4'h9;

    localparam int NUM_SETTINGS = 10;
    localparam logic [13:0] SETTING_RESET = 14'h0000;
    localparam logic [13:0] FULL_MASK = 14'h3fff;
    localparam logic [13:0] LOW_MASK = 14'h007f;
    localparam logic [13:0] HIGH_MASK = 14'h3f80;
    localparam logic [6:0] CHK_MASK = 7'h7f;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam int ADDR_FLAG_BIT = 7;
    localparam int WRITE_FLAG_BIT = 6;

    // simple protocol command bytes
    localparam logic [7:0] S_WR_SPEED = 8'h80;
    localparam logic [7:0] S_WR_UNUSED = 8'h81;
    localparam logic [7:0] S_WR_DIR = 8'h8a;
    localparam logic [7:0] S_SAVE_LO = 8'ha0;
    localparam logic [7:0] S_SAVE_HI = 8'ha1;
    localparam logic [7:0] S_RD_FIRST = 8'hc0;
    localparam logic [7:0] S_RD_LAST_SET = 8'hc9;
    localparam logic [7:0] S_RD_CURRENT = 8'hca;
    localparam logic [7:0] S_RD_SUPPLY = 8'hcc;
    localparam logic [7:0] S_RD_SPEED_IN = 8'hcd;
    localparam logic [7:0] S_RD_HEATSINK = 8'hce;
    localparam logic [7:0] S_RD_BOARD = 8'hcf;
    localparam logic [7:0] S_RD_STAT_LO = 8'hd0;
    localparam logic [7:0] S_RD_STAT_HI = 8'hd1;
    localparam logic [7:0] S_RD_CFG1_LO = 8'hd2;
    localparam logic [7:0] S_RD_CFG1_HI = 8'hd3;
    localparam logic [7:0] S_RD_CFG2_LO = 8'hd4;
    localparam logic [7:0] S_RD_CFG2_HI = 8'hd5;
    localparam logic [7:0] S_RD_SW_VER = 8'hde;
    localparam logic [7:0] S_RD_HW_VER = 8'hdf;
    localparam logic [7:0] S_SERIAL_AUTO = 8'he0;
    localparam logic [7:0] S_SERIAL_HOLD = 8'he1;
    localparam logic [7:0] S_SERIAL_CANCEL = 8'he2;

    // advanced register codes, low six bits of the read or write command
    localparam logic [5:0] A_SPEED = 6'h00;
    localparam logic [5:0] A_HEATSINK = 6'h0a;
    localparam logic [5:0] A_BOARD = 6'h0b;
    localparam logic [5:0] A_SUPPLY = 6'h10;
    localparam logic [5:0] A_SPEED_IN = 6'h11;
    localparam logic [5:0] A_CURRENT = 6'h12;
    localparam logic [5:0] A_STATUS = 6'h30;
    localparam logic [5:0] A_LOCK = 6'h31;
    localparam logic [5:0] A_SAVE1 = 6'h32;
    localparam logic [5:0] A_SAVE2 = 6'h33;
    localparam logic [5:0] A_CFG1 = 6'h34;
    localparam logic [5:0] A_CFG2 = 6'h35;
    localparam logic [5:0] A_ADDR = 6'h3c;
    localparam logic [5:0] A_CAL = 6'h3d;
    localparam logic [5:0] A_SW_VER = 6'h3e;
    localparam logic [5:0] A_HW_VER = 6'h3f;

    localparam logic [1:0] DIR_STOP = 2'h0;
    localparam logic [1:0] DIR_FWD = 2'h1;
    localparam logic [1:0] DIR_REGEN = 2'h3;

    typedef struct packed {
        logic [13:0] current;
        logic [13:0] supply;
        logic [13:0] speed_in;
        logic [13:0] heatsink_temp;
        logic [13:0] board_temp;
        logic [13:0] status;
    } measurements_s;

    typedef struct packed {
        logic [NUM_SETTINGS-1:0][13:0] setting;
        logic [1:0] dir;
        logic [13:0] lock;
        logic [13:0] save1;
        logic [13:0] save2;
        logic [13:0] cfg1;
        logic [13:0] cfg2;
        logic [13:0] cal;
        logic serial_ctrl;
        logic autostop_on;
    } control_s;

endpackage
